// ---- dpram_host_defines.vh ----
// Pin timing, address map and command codes for the dual-port RAM host
`ifndef DPRAM_HOST_DEFINES_VH
`define DPRAM_HOST_DEFINES_VH

`define CLK_PERIOD_NS      5
`define ADDR_W             14
`define DATA_W             8
`define CNT_W              8

// Pin timing in ns
`define SELECT_TO_DATA_NS  25
`define OE_TO_DATA_NS      13
`define WRITE_PULSE_NS     20
`define DATA_SETUP_NS      15
`define FLOWTHROUGH_NS     50
`define MATCH_TO_FLAG_NS   20
`define SELECT_TO_FLAG_NS  20
`define SEM_RECOVERY_NS    10
`define SEM_WR_TO_RD_NS    10

// Least times, rounded up to whole clock cycles
`define NS2CYC(t)          (((t) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SELECT_TO_DATA_CYC `NS2CYC(`SELECT_TO_DATA_NS)
`define OE_TO_DATA_CYC     `NS2CYC(`OE_TO_DATA_NS)
`define WRITE_PULSE_CYC    `NS2CYC(`WRITE_PULSE_NS)
`define DATA_SETUP_CYC     `NS2CYC(`DATA_SETUP_NS)
`define FLOWTHROUGH_CYC    `NS2CYC(`FLOWTHROUGH_NS)
`define MATCH_TO_FLAG_CYC  `NS2CYC(`MATCH_TO_FLAG_NS)
`define SELECT_TO_FLAG_CYC `NS2CYC(`SELECT_TO_FLAG_NS)
`define SEM_RECOVERY_CYC   `NS2CYC(`SEM_RECOVERY_NS)
`define SEM_WR_TO_RD_CYC   `NS2CYC(`SEM_WR_TO_RD_NS)
`define SYNC_LAT_CYC       3

// Mailbox locations
`define MBOX_RIGHT_8K      14'h1FFF
`define MBOX_LEFT_8K       14'h1FFE
`define MBOX_RIGHT_16K     14'h3FFF
`define MBOX_LEFT_16K      14'h3FFE

// Semaphore latch select field
`define SEM_IDX_W          3

// User command codes
`define CMD_READ           3'h0
`define CMD_WRITE          3'h1
`define CMD_SEM_CLAIM      3'h2
`define CMD_SEM_RELEASE    3'h3
`define CMD_SEM_READ       3'h4
`define CMD_MAIL_SEND      3'h5
`define CMD_MAIL_READ      3'h6

`endif

// ---- pin_sync.v ----
// Three-stage pin synchroniser; output changes when stages two and three agree
`timescale 1ns/1ps
module pin_sync #(
	parameter W    = 1,
	parameter INIT = 1'b1
) (
	input  wire         clk_sys,
	input  wire         rst_n,
	input  wire [W-1:0] pin_in,
	output reg  [W-1:0] level_q
);
	reg [W-1:0] s1_q;
	reg [W-1:0] s2_q;
	reg [W-1:0] s3_q;

	// Chain of three, stage one read only by stage two
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			s1_q    <= {W{INIT}};
			s2_q    <= {W{INIT}};
			s3_q    <= {W{INIT}};
			level_q <= {W{INIT}};
		end else begin
			s1_q <= pin_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
			if (s2_q == s3_q) begin
				level_q <= s3_q;
			end
		end
	end
endmodule

// ---- dpram_host.v ----
// Host controller driving one port of an asynchronous dual-port RAM
`timescale 1ns/1ps
`include "dpram_host_defines.vh"
module dpram_host (
	input  wire                    clk_sys,
	input  wire                    rst_n,
	input  wire                    port_is_right,
	input  wire                    array_is_16k,
	input  wire                    cmd_valid,
	input  wire [2:0]              cmd_code,
	input  wire [`ADDR_W-1:0]      cmd_addr,
	input  wire [`DATA_W-1:0]      cmd_wdata,
	output reg                     cmd_ready_q,
	output reg                     done_q,
	output reg  [`DATA_W-1:0]      rdata_q,
	output reg                     sem_owned_q,
	output reg                     contention_seen_q,
	output reg                     mail_irq_q,
	output reg                     port_select_n_q,
	output reg                     semaphore_select_n_q,
	output reg                     read_write_n_q,
	output reg                     output_drive_n_q,
	output reg  [`ADDR_W-1:0]      addr_q,
	output reg  [`DATA_W-1:0]      data_out_q,
	output reg                     data_oe_n_q,
	input  wire [`DATA_W-1:0]      data_in,
	input  wire                    contention_n,
	input  wire                    mail_int_n
);
	localparam [2:0] ST_IDLE    = 3'h0;
	localparam [2:0] ST_SETTLE  = 3'h1;
	localparam [2:0] ST_WPULSE  = 3'h2;
	localparam [2:0] ST_WEND    = 3'h3;
	localparam [2:0] ST_READ    = 3'h4;
	localparam [2:0] ST_RECOVER = 3'h5;

	// Sizes a cycle count to the counter width
	function [`CNT_W-1:0] cyc;
		input integer n;
		begin
			cyc = n[`CNT_W-1:0];
		end
	endfunction

	// Larger of two cycle counts
	function [`CNT_W-1:0] cmax;
		input [`CNT_W-1:0] a;
		input [`CNT_W-1:0] b;
		begin
			cmax = (a > b) ? a : b;
		end
	endfunction

	wire [`CNT_W-1:0] flag_settle = cmax(cyc(`MATCH_TO_FLAG_CYC),
		cyc(`SELECT_TO_FLAG_CYC)) + cyc(`SYNC_LAT_CYC);
	wire [`CNT_W-1:0] read_wait = cmax(cyc(`SELECT_TO_DATA_CYC),
		cyc(`OE_TO_DATA_CYC)) + cyc(`SYNC_LAT_CYC);
	wire [`CNT_W-1:0] pulse_wait = cmax(cyc(`WRITE_PULSE_CYC),
		cyc(`DATA_SETUP_CYC));
	wire [`CNT_W-1:0] sem_gap = cmax(cyc(`SEM_RECOVERY_CYC),
		cyc(`SEM_WR_TO_RD_CYC));

	wire               busy_sync_n;
	wire               int_sync_n;
	wire [`DATA_W-1:0] data_sync;

	// Flag pins from the device are asynchronous to clk_sys
	pin_sync #(.W(1), .INIT(1'b1)) u_busy_sync (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.pin_in  (contention_n),
		.level_q (busy_sync_n)
	);
	pin_sync #(.W(1), .INIT(1'b1)) u_int_sync (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.pin_in  (mail_int_n),
		.level_q (int_sync_n)
	);
	pin_sync #(.W(`DATA_W), .INIT(1'b0)) u_data_sync (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.pin_in  (data_in),
		.level_q (data_sync)
	);

	// Mailbox addresses for each port and array size
	wire [`ADDR_W-1:0] own_mbox = array_is_16k ?
		(port_is_right ? `MBOX_RIGHT_16K : `MBOX_LEFT_16K) :
		(port_is_right ? `MBOX_RIGHT_8K : `MBOX_LEFT_8K);
	wire [`ADDR_W-1:0] peer_mbox = array_is_16k ?
		(port_is_right ? `MBOX_LEFT_16K : `MBOX_RIGHT_16K) :
		(port_is_right ? `MBOX_LEFT_8K : `MBOX_RIGHT_8K);

	reg [2:0]         state_q;
	reg [`CNT_W-1:0]  cnt_q;
	reg               is_write_q;
	reg               is_sem_q;
	reg               polling_q;
	reg               contended_q;

	// Command capture, pin sequencing and result reporting
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state_q              <= ST_IDLE;
			cnt_q                <= {`CNT_W{1'b0}};
			is_write_q           <= 1'b0;
			is_sem_q             <= 1'b0;
			polling_q            <= 1'b0;
			contended_q          <= 1'b0;
			cmd_ready_q          <= 1'b1;
			done_q               <= 1'b0;
			rdata_q              <= {`DATA_W{1'b0}};
			sem_owned_q          <= 1'b0;
			contention_seen_q    <= 1'b0;
			mail_irq_q           <= 1'b0;
			port_select_n_q      <= 1'b1;
			semaphore_select_n_q <= 1'b1;
			read_write_n_q       <= 1'b1;
			output_drive_n_q     <= 1'b1;
			addr_q               <= {`ADDR_W{1'b0}};
			data_out_q           <= {`DATA_W{1'b0}};
			data_oe_n_q          <= 1'b1;
		end else begin
			done_q     <= 1'b0;
			mail_irq_q <= ~int_sync_n;
			case (state_q)
			ST_IDLE: begin
				if (cmd_valid && cmd_ready_q) begin
					cmd_ready_q <= 1'b0;
					contended_q <= 1'b0;
					polling_q   <= 1'b0;
					addr_q      <= cmd_addr;
					data_out_q  <= cmd_wdata;
					is_write_q  <= 1'b0;
					is_sem_q    <= 1'b0;
					case (cmd_code)
					`CMD_WRITE: begin
						is_write_q <= 1'b1;
					end
					`CMD_SEM_CLAIM: begin
						is_sem_q   <= 1'b1;
						is_write_q <= 1'b1;
						polling_q  <= 1'b1;
						data_out_q <= {`DATA_W{1'b0}};
					end
					`CMD_SEM_RELEASE: begin
						is_sem_q   <= 1'b1;
						is_write_q <= 1'b1;
						data_out_q <= {{(`DATA_W-1){1'b0}}, 1'b1};
					end
					`CMD_SEM_READ: begin
						is_sem_q <= 1'b1;
					end
					`CMD_MAIL_SEND: begin
						is_write_q <= 1'b1;
						addr_q     <= peer_mbox;
					end
					`CMD_MAIL_READ: begin
						addr_q <= own_mbox;
					end
					default: begin
						is_write_q <= 1'b0;
					end
					endcase
					// Semaphore uses its own select, port select stays high
					if (cmd_code == `CMD_SEM_CLAIM ||
						cmd_code == `CMD_SEM_RELEASE ||
						cmd_code == `CMD_SEM_READ) begin
						semaphore_select_n_q <= 1'b0;
						addr_q <= {{(`ADDR_W-`SEM_IDX_W){1'b0}},
							cmd_addr[`SEM_IDX_W-1:0]};
					end else begin
						port_select_n_q <= 1'b0;
					end
					cnt_q   <= flag_settle;
					state_q <= ST_SETTLE;
				end
			end
			ST_SETTLE: begin
				// Hold off until the contention flag has settled and, for port accesses, cleared
				if (cnt_q != {`CNT_W{1'b0}}) begin
					cnt_q <= cnt_q - 1'b1;
				end else if (!busy_sync_n && !is_sem_q) begin
					contended_q       <= 1'b1;
					contention_seen_q <= 1'b1;
				end else if (is_write_q) begin
					read_write_n_q <= 1'b0;
					data_oe_n_q    <= 1'b0;
					cnt_q          <= pulse_wait;
					state_q        <= ST_WPULSE;
				end else begin
					output_drive_n_q <= 1'b0;
					cnt_q <= contended_q ?
						read_wait + cyc(`FLOWTHROUGH_CYC) : read_wait;
					state_q <= ST_READ;
				end
			end
			ST_WPULSE: begin
				if (cnt_q > {{(`CNT_W-1){1'b0}}, 1'b1}) begin
					cnt_q <= cnt_q - 1'b1;
				end else begin
					read_write_n_q <= 1'b1;
					state_q        <= ST_WEND;
				end
			end
			ST_WEND: begin
				// Data held one cycle past the rising write edge
				data_oe_n_q          <= 1'b1;
				port_select_n_q      <= 1'b1;
				semaphore_select_n_q <= 1'b1;
				cnt_q                <= sem_gap;
				state_q              <= ST_RECOVER;
				if (is_sem_q && !polling_q) begin
					sem_owned_q <= 1'b0;
				end
			end
			ST_READ: begin
				if (cnt_q != {`CNT_W{1'b0}}) begin
					cnt_q <= cnt_q - 1'b1;
				end else begin
					output_drive_n_q     <= 1'b1;
					port_select_n_q      <= 1'b1;
					semaphore_select_n_q <= 1'b1;
					rdata_q              <= data_sync;
					if (is_sem_q) begin
						sem_owned_q <= ~data_sync[0];
					end
					if (polling_q && data_sync[0]) begin
						cnt_q   <= sem_gap;
						state_q <= ST_RECOVER;
					end else begin
						polling_q   <= 1'b0;
						done_q      <= 1'b1;
						cmd_ready_q <= 1'b1;
						state_q     <= ST_IDLE;
					end
				end
			end
			ST_RECOVER: begin
				// Selects held high before the read back or next command
				if (cnt_q != {`CNT_W{1'b0}}) begin
					cnt_q <= cnt_q - 1'b1;
				end else if (polling_q) begin
					is_write_q           <= 1'b0;
					semaphore_select_n_q <= 1'b0;
					cnt_q                <= flag_settle;
					state_q              <= ST_SETTLE;
				end else begin
					done_q      <= 1'b1;
					cmd_ready_q <= 1'b1;
					state_q     <= ST_IDLE;
				end
			end
			default: begin
				state_q <= ST_IDLE;
			end
			endcase
		end
	end
endmodule

// ---- dpram_host_checker.sv ----
// Pin protocol checker for the dual-port RAM host
`timescale 1ns/1ps
module dpram_host_checker (
	input logic clk_sys,
	input logic rst_n,
	input logic port_select_n_q,
	input logic semaphore_select_n_q,
	input logic read_write_n_q,
	input logic output_drive_n_q,
	input logic contention_n,
	input logic contention_seen_q
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);
	logic busy_acc;
	// Remembers a contention flag seen while the port is selected
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			busy_acc <= 1'b0;
		else
			busy_acc <= !port_select_n_q && (busy_acc || !contention_n);
	end
	// Write strobe phase and semaphore recovery phase
	sequence s_wr_pulse;
		!read_write_n_q [*4];
	endsequence
	sequence s_sem_rest;
		semaphore_select_n_q [*2];
	endsequence
	a_write_selected: assert property (
		!read_write_n_q |-> !(port_select_n_q && semaphore_select_n_q))
		else $error("write strobe without select");
	a_write_pulse: assert property (
		$fell(read_write_n_q) |-> s_wr_pulse) else $error("short write");
	a_read_wait: assert property (
		$rose(output_drive_n_q) |-> !$past(output_drive_n_q, 6))
		else $error("read too short");
	a_read_flow: assert property (
		$rose(output_drive_n_q) && !$past(port_select_n_q) && busy_acc
		|-> !$past(output_drive_n_q, 13))
		else $error("no flowthrough wait");
	a_write_settled: assert property (
		$fell(read_write_n_q) && !port_select_n_q
		|-> !$past(port_select_n_q, 7) && $past(contention_n, 2))
		else $error("write before flag settled");
	a_sem_exclusive: assert property (
		!semaphore_select_n_q |-> port_select_n_q) else $error("two selects");
	a_sem_recovery: assert property (
		$rose(semaphore_select_n_q) && !$past(read_write_n_q, 2)
		|-> s_sem_rest) else $error("no recovery");
	a_seen_flag: assert property (
		$rose(contention_seen_q)
		|-> !$past(contention_n, 4) || !$past(contention_n, 5))
		else $error("contention seen without flag");
endmodule
bind dpram_host dpram_host_checker chk_u (.clk_sys(clk_sys), .rst_n(rst_n),
	.port_select_n_q(port_select_n_q),
	.semaphore_select_n_q(semaphore_select_n_q),
	.read_write_n_q(read_write_n_q), .output_drive_n_q(output_drive_n_q),
	.contention_n(contention_n), .contention_seen_q(contention_seen_q));

// ---- dpram_dev_model.sv ----
// Behavioural model of the dual-port RAM as seen from one port
`timescale 1ns/1ps
module dpram_dev_model (
	input  logic        port_select_n,
	input  logic        semaphore_select_n,
	input  logic        read_write_n,
	input  logic        output_drive_n,
	input  logic [13:0] addr,
	input  logic [7:0]  wdata,
	input  logic        busy_n,
	output logic [7:0]  rdata,
	output logic        contention_n,
	output logic        mail_int_n
);
	logic [7:0] mem [0:16383];
	logic [7:0] host_own = 8'h00;
	logic [7:0] peer_own = 8'h00;
	logic [7:0] host_pend = 8'h00;
	logic [7:0] peer_pend = 8'h00;
	logic [7:0] lat = 8'h00;
	logic       drv = 1'b0;
	logic       peer_irq = 1'b0;
	logic       irq_n = 1'b1;
	// Released bus shows the inverse of the last value
	assign contention_n = busy_n;
	assign mail_int_n = irq_n;
	assign rdata = drv ? lat : ~lat;
	// Semaphore write from either side, data bit 0 only
	task sem_wr(input peer, input [2:0] i, input v);
		if (!v && !host_own[i] && !peer_own[i]) begin
			peer_own[i] = peer;
			host_own[i] = !peer;
		end else if (!v) begin
			peer_pend[i] = peer_pend[i] | peer;
			host_pend[i] = host_pend[i] | !peer;
		end else if (peer ? peer_own[i] : host_own[i]) begin
			peer_own[i] = !peer && peer_pend[i];
			host_own[i] = peer && host_pend[i];
			peer_pend[i] = 1'b0;
			host_pend[i] = 1'b0;
		end
	endtask
	// Host write lands at the end of the strobe
	always @(posedge read_write_n) begin
		if (!port_select_n) begin
			mem[addr] = wdata;
			if (addr == 14'h3FFE && busy_n) peer_irq = 1'b1;
		end else if (!semaphore_select_n) begin
			sem_wr(1'b0, addr[2:0], wdata[0]);
		end
	end
	// Read value latched as output drive falls, shown after the delay
	always @(negedge output_drive_n) begin
		if (!port_select_n) begin
			lat = mem[addr];
			if (addr == 14'h3FFF && busy_n) irq_n = 1'b1;
		end else if (!semaphore_select_n) begin
			lat = {8{!host_own[addr[2:0]]}};
		end
		drv <= #13 1'b1;
	end
	always @(posedge output_drive_n) drv = 1'b0;
	// Other port writes a word
	task peer_write(input [13:0] a, input [7:0] d);
		mem[a] = d;
		if (a == 14'h3FFF) irq_n = 1'b0;
	endtask
endmodule

// ---- test_dpram_host.sv ----
// Self-checking testbench for the dual-port RAM host
`timescale 1ns/1ps
module test_dpram_host;
	logic        clk_sys = 1'b0;
	logic        rst_n = 1'b0;
	logic        cmd_valid = 1'b0;
	logic [2:0]  cmd_code = 3'h0;
	logic [13:0] cmd_addr = 14'h0000;
	logic [7:0]  cmd_wdata = 8'h00;
	logic        busy_n = 1'b1;
	logic        right_port = 1'b1;
	logic        big_array = 1'b1;
	logic        cmd_ready_q;
	logic        done_q, sem_owned_q, contention_seen_q, mail_irq_q;
	logic        ps_n, ss_n, rw_n, od_n, doe_n, cont_n, int_n;
	logic [13:0] addr;
	logic [7:0]  rdata_q, dout, din, dev_d;
	integer      n_mismatch = 0;
	integer      comparisons = 0;
	// Clock and shared data wire
	always #2.5 clk_sys = ~clk_sys;
	assign din = !doe_n ? dout : dev_d;
	dpram_host dut_u (.clk_sys(clk_sys), .rst_n(rst_n),
		.port_is_right(right_port), .array_is_16k(big_array),
		.cmd_valid(cmd_valid), .cmd_code(cmd_code),
		.cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
		.cmd_ready_q(cmd_ready_q),
		.done_q(done_q), .rdata_q(rdata_q), .sem_owned_q(sem_owned_q),
		.contention_seen_q(contention_seen_q), .mail_irq_q(mail_irq_q),
		.port_select_n_q(ps_n), .semaphore_select_n_q(ss_n),
		.read_write_n_q(rw_n), .output_drive_n_q(od_n), .addr_q(addr),
		.data_out_q(dout), .data_oe_n_q(doe_n), .data_in(din),
		.contention_n(cont_n), .mail_int_n(int_n));
	dpram_dev_model dev_u (.port_select_n(ps_n), .semaphore_select_n(ss_n),
		.read_write_n(rw_n), .output_drive_n(od_n), .addr(addr),
		.wdata(dout), .busy_n(busy_n), .rdata(dev_d),
		.contention_n(cont_n), .mail_int_n(int_n));
	// Compare and count
	task chk(input [7:0] seen, input [7:0] exp);
		comparisons = comparisons + 1;
		if (seen !== exp) begin
			n_mismatch = n_mismatch + 1;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// One command, waiting a bounded time for its end
	task cmd(input [2:0] c, input [13:0] a, input [7:0] d);
		integer i;
		@(negedge clk_sys);
		cmd_valid = 1'b1;
		cmd_code = c;
		cmd_addr = a;
		cmd_wdata = d;
		@(negedge clk_sys);
		cmd_valid = 1'b0;
		chk(cmd_ready_q, 8'h00);
		for (i = 0; i < 3000 && done_q !== 1'b1; i = i + 1)
			@(negedge clk_sys);
		chk(done_q, 8'h01);
	endtask
	task test_done;
		$display("comparisons=%0d n_mismatch=%0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// Back-to-back writes then reads, up to two words below the array top
	task t_mem;
		integer k;
		for (k = 0; k < 4; k = k + 1) begin
			cmd(3'h1, {k[1:0], 12'hFFD}, 8'hA5 ^ k[7:0]);
			chk(dev_u.mem[{k[1:0], 12'hFFD}], 8'hA5 ^ k[7:0]);
		end
		for (k = 0; k < 4; k = k + 1) begin
			cmd(3'h0, {k[1:0], 12'hFFD}, 8'h00);
			chk(rdata_q, 8'hA5 ^ k[7:0]);
		end
	endtask
	// Write held off by the contention flag, then read after it
	task t_busy;
		cmd(3'h1, 14'h0100, 8'h11);
		busy_n = 1'b0;
		fork
			cmd(3'h1, 14'h0100, 8'h5A);
			begin
				repeat (60) @(negedge clk_sys);
				chk(dev_u.mem[14'h0100], 8'h11);
				busy_n = 1'b1;
			end
		join
		chk(dev_u.mem[14'h0100], 8'h5A);
		chk(contention_seen_q, 8'h01);
		cmd(3'h0, 14'h0100, 8'h00);
		chk(rdata_q, 8'h5A);
		busy_n = 1'b0;
		fork
			cmd(3'h0, 14'h0100, 8'h00);
			begin
				repeat (40) @(negedge clk_sys);
				busy_n = 1'b1;
			end
		join
		chk(rdata_q, 8'h5A);
	endtask
	// Left port on an 8K array: mailboxes move to the lower pair
	task t_strap;
		right_port = 1'b0;
		big_array = 1'b0;
		dev_u.peer_write(14'h1FFE, 8'hC3);
		cmd(3'h6, 14'h0000, 8'h00);
		chk(rdata_q, 8'hC3);
		cmd(3'h5, 14'h0000, 8'h96);
		chk(dev_u.mem[14'h1FFF], 8'h96);
	endtask
	// Mailbox interrupt raised, kept on a foreign read, cleared on own
	task t_mail;
		dev_u.peer_write(14'h3FFF, 8'h3C);
		repeat (10) @(negedge clk_sys);
		chk(mail_irq_q, 8'h01);
		cmd(3'h0, 14'h3FFE, 8'h00);
		repeat (6) @(negedge clk_sys);
		chk(mail_irq_q, 8'h01);
		cmd(3'h6, 14'h0000, 8'h00);
		chk(rdata_q, 8'h3C);
		repeat (6) @(negedge clk_sys);
		chk(mail_irq_q, 8'h00);
		cmd(3'h5, 14'h0000, 8'h77);
		chk(dev_u.mem[14'h3FFE], 8'h77);
		chk(dev_u.peer_irq, 8'h01);
	endtask
	// Claim, read, release, and polling while the other port holds
	task t_sem;
		cmd(3'h2, 14'h3FF5, 8'h00);
		chk(sem_owned_q, 8'h01);
		chk(dev_u.host_own, 8'h20);
		cmd(3'h4, 14'h0005, 8'h00);
		chk(rdata_q, 8'h00);
		cmd(3'h3, 14'h0005, 8'h00);
		chk(sem_owned_q, 8'h00);
		chk(dev_u.host_own, 8'h00);
		dev_u.sem_wr(1'b1, 3'h2, 1'b0);
		cmd(3'h4, 14'h0002, 8'h00);
		chk(rdata_q, 8'hFF);
		fork
			cmd(3'h2, 14'h0002, 8'h00);
			begin
				repeat (100) @(negedge clk_sys);
				chk(sem_owned_q, 8'h00);
				dev_u.sem_wr(1'b1, 3'h2, 1'b1);
			end
		join
		chk(sem_owned_q, 8'h01);
		chk(dev_u.host_own, 8'h04);
	endtask
	// Main sequence
	initial begin
		repeat (20) @(negedge clk_sys);
		rst_n = 1'b1;
		t_mem;
		t_busy;
		t_mail;
		t_sem;
		t_strap;
		test_done;
	end
	// Watchdog
	initial begin
		#200000;
		n_mismatch = n_mismatch + 1;
		test_done;
	end
endmodule
